// *** core/fwsr_pkg.sv ***
// shared constants and types of the flash write-status host controller
package fwsr_pkg;

	// ----------------------------------------------------------------
	// bus timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_STROBE_NS = 70;
	localparam int T_RECOVER_NS = 30;
	localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// addresses and command data
	// ----------------------------------------------------------------
	localparam int ADDR_W = 22;
	localparam logic [21:0] UNLOCK_ADDR_1 = 22'h000555;
	localparam logic [21:0] UNLOCK_ADDR_2 = 22'h0002AA;
	localparam logic [7:0] CMD_UNLOCK_1 = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK_2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hF0;

	// ----------------------------------------------------------------
	// status bit positions
	// ----------------------------------------------------------------
	localparam int DATA_POLL_BIT = 7;
	localparam int TOGGLE_BIT_ONE = 6;
	localparam int TIMING_LIMIT_FLAG = 5;
	localparam int ERASE_TIMER_FLAG = 3;
	localparam int TOGGLE_BIT_TWO = 2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SECT_ADD,
		OP_SUSPEND, OP_RESUME, OP_RESET, OP_POLL
	} fwsr_op_type;

	typedef struct packed {
		fwsr_op_type op;
		logic [21:0] addr;
		logic [7:0] data;
		logic poll;
	} fwsr_req_type;

	typedef struct packed {
		logic ok;
		logic timing_fail;
		logic rejected;
		logic late_timer;
		logic ready;
		logic [7:0] data;
	} fwsr_resp_type;

	typedef struct packed {
		logic [21:0] addr;
		logic [7:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} fwsr_pins_type;

	typedef struct packed {
		logic [21:0] addr;
		logic [7:0] data;
		logic last;
	} fwsr_word_type;

	localparam fwsr_pins_type PINS_IDLE = '{addr: 22'h000000,
		dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

	typedef enum logic [1:0] {
		CY_IDLE, CY_SETUP, CY_STROBE, CY_RECOVER
	} fwsr_cyc_state_type;

	typedef enum logic [3:0] {
		M_IDLE, M_WRITE, M_POLL_A, M_POLL_B, M_PRE_CHK, M_POST_CHK,
		M_READ, M_FINISH
	} fwsr_main_state_type;

endpackage

// *** core/fwsr_cycle.sv ***
// one read or write bus cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fwsr_cycle (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic start,
	input wire logic write,
	input wire logic [21:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] dq_in,
	output fwsr_pkg::fwsr_pins_type pins,
	output logic [7:0] rdata,
	output logic busy,
	output logic done
);
	import fwsr_pkg::*;

	typedef struct packed {
		fwsr_cyc_state_type st;
		logic [2:0] cnt;
		logic write;
		fwsr_pins_type pins;
		logic [7:0] rdata;
		logic done;
	} fwsr_cyc_type;

	fwsr_cyc_type s;
	fwsr_cyc_type next_s;

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		case (s.st)
			CY_IDLE: begin
				if (start) begin
					next_s.st = CY_SETUP;
					next_s.write = write;
					next_s.pins.addr = addr;
					next_s.pins.dq_out = wdata;
					next_s.pins.ce_n = 1'b0;
				end
			end
			CY_SETUP: begin
				next_s.st = CY_STROBE;
				next_s.cnt = 3'(STROBE_CYC - 1);
				if (s.write) begin
					next_s.pins.we_n = 1'b0;
					next_s.pins.dq_oe = 1'b1;
				end else begin
					next_s.pins.oe_n = 1'b0;
				end
			end
			CY_STROBE: begin
				if (s.cnt == 3'h0) begin
					// rising strobe edge: device latches data, status goes valid
					next_s.st = CY_RECOVER;
					next_s.cnt = 3'(RECOVER_CYC - 1);
					next_s.pins.we_n = 1'b1;
					next_s.pins.oe_n = 1'b1;
					if (!s.write) begin
						next_s.rdata = dq_in;
					end
				end else begin
					next_s.cnt = s.cnt - 3'h1;
				end
			end
			CY_RECOVER: begin
				// oe_n returns high so every status read is a distinct read
				if (s.cnt == 3'h0) begin
					next_s.st = CY_IDLE;
					next_s.pins.ce_n = 1'b1;
					next_s.pins.dq_oe = 1'b0;
					next_s.done = 1'b1;
				end else begin
					next_s.cnt = s.cnt - 3'h1;
				end
			end
			default: begin
				next_s.st = CY_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= '{st: CY_IDLE, cnt: 3'h0, write: 1'b0, pins: PINS_IDLE,
				rdata: 8'h00, done: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign pins = s.pins;
	assign rdata = s.rdata;
	assign done = s.done;
	assign busy = (s.st != CY_IDLE);

endmodule
`default_nettype wire

// *** core/fwsr_host.sv ***
// host controller running program, erase and status polling on the flash
`timescale 1ns/1ps
`default_nettype none
module fwsr_host (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic req_valid,
	output logic req_ready,
	input wire fwsr_pkg::fwsr_req_type req,
	output logic resp_valid,
	output fwsr_pkg::fwsr_resp_type resp,
	output fwsr_pkg::fwsr_pins_type flash_pins,
	input wire logic [7:0] dq_in,
	input wire logic ready_busy_n
);
	import fwsr_pkg::*;

	// ----------------------------------------------------------------
	// command sequence table
	// ----------------------------------------------------------------
	function automatic fwsr_word_type seq_word(fwsr_op_type op,
		logic [2:0] step, logic [21:0] addr, logic [7:0] data);
		fwsr_word_type w;
		w = '{addr: UNLOCK_ADDR_1, data: CMD_RESET, last: 1'b1};
		case (op)
			OP_PROGRAM: begin
				case (step)
					3'h0: w = '{UNLOCK_ADDR_1, CMD_UNLOCK_1, 1'b0};
					3'h1: w = '{UNLOCK_ADDR_2, CMD_UNLOCK_2, 1'b0};
					3'h2: w = '{UNLOCK_ADDR_1, CMD_PROGRAM, 1'b0};
					default: w = '{addr, data, 1'b1};
				endcase
			end
			OP_CHIP_ERASE, OP_SECT_ERASE: begin
				case (step)
					3'h0: w = '{UNLOCK_ADDR_1, CMD_UNLOCK_1, 1'b0};
					3'h1: w = '{UNLOCK_ADDR_2, CMD_UNLOCK_2, 1'b0};
					3'h2: w = '{UNLOCK_ADDR_1, CMD_ERASE_SETUP, 1'b0};
					3'h3: w = '{UNLOCK_ADDR_1, CMD_UNLOCK_1, 1'b0};
					3'h4: w = '{UNLOCK_ADDR_2, CMD_UNLOCK_2, 1'b0};
					default: begin
						if (op == OP_CHIP_ERASE) begin
							w = '{UNLOCK_ADDR_1, CMD_CHIP_ERASE, 1'b1};
						end else begin
							w = '{addr, CMD_SECTOR_ERASE, 1'b1};
						end
					end
				endcase
			end
			OP_SECT_ADD: w = '{addr, CMD_SECTOR_ERASE, 1'b1};
			OP_SUSPEND: w = '{UNLOCK_ADDR_1, CMD_SUSPEND, 1'b1};
			OP_RESUME: w = '{UNLOCK_ADDR_1, CMD_RESUME, 1'b1};
			default: w = '{UNLOCK_ADDR_1, CMD_RESET, 1'b1};
		endcase
		return w;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		fwsr_main_state_type st;
		fwsr_op_type op;
		logic [21:0] addr;
		logic [7:0] data;
		logic poll;
		logic [2:0] step;
		logic issued;
		logic first_toggle;
		logic rechk;
		logic resp_valid;
		fwsr_resp_type resp;
	} fwsr_main_type;

	fwsr_main_type s;
	fwsr_main_type next_s;
	fwsr_word_type w;
	logic cyc_start;
	logic cyc_write;
	logic [21:0] cyc_addr;
	logic [7:0] cyc_wdata;
	logic [7:0] cyc_rdata;
	logic cyc_busy;
	logic cyc_done;
	logic rd_done;

	fwsr_cycle u_cycle (
		.mclk(mclk),
		.rstn(rstn),
		.start(cyc_start),
		.write(cyc_write),
		.addr(cyc_addr),
		.wdata(cyc_wdata),
		.dq_in(dq_in),
		.pins(flash_pins),
		.rdata(cyc_rdata),
		.busy(cyc_busy),
		.done(cyc_done)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.resp_valid = 1'b0;
		w = seq_word(s.op, s.step, s.addr, s.data);
		cyc_write = 1'b0;
		cyc_addr = s.addr;
		cyc_wdata = s.data;
		cyc_start = (s.st != M_IDLE) && (s.st != M_FINISH) && !s.issued &&
			!cyc_busy;
		rd_done = s.issued && cyc_done;
		if (cyc_start) begin
			next_s.issued = 1'b1;
		end
		if (cyc_done) begin
			next_s.issued = 1'b0;
		end
		case (s.st)
			M_IDLE: begin
				if (req_valid) begin
					next_s.op = req.op;
					next_s.addr = req.addr;
					next_s.data = req.data;
					next_s.poll = req.poll;
					next_s.step = 3'h0;
					next_s.rechk = 1'b0;
					next_s.resp = '0;
					case (req.op)
						OP_READ: next_s.st = M_READ;
						OP_POLL: next_s.st = M_POLL_A;
						OP_SECT_ADD: next_s.st = M_PRE_CHK;
						default: next_s.st = M_WRITE;
					endcase
				end
			end
			M_WRITE: begin
				cyc_write = 1'b1;
				cyc_addr = w.addr;
				cyc_wdata = w.data;
				if (rd_done) begin
					next_s.step = s.step + 3'h1;
					if (w.last) begin
						// polling starts only after the final strobe edge
						case (s.op)
							OP_PROGRAM, OP_CHIP_ERASE, OP_SUSPEND: begin
								next_s.st = M_POLL_A;
							end
							OP_SECT_ERASE: begin
								next_s.st = s.poll ? M_POLL_A : M_FINISH;
							end
							OP_SECT_ADD: next_s.st = M_POST_CHK;
							default: next_s.st = M_FINISH;
						endcase
					end
				end
			end
			M_POLL_A: begin
				// first of the double read, restarted on every pass
				if (rd_done) begin
					next_s.first_toggle = cyc_rdata[TOGGLE_BIT_ONE];
					next_s.st = M_POLL_B;
				end
			end
			M_POLL_B: begin
				if (rd_done) begin
					next_s.resp.data = cyc_rdata;
					if (cyc_rdata[TOGGLE_BIT_ONE] == s.first_toggle) begin
						next_s.st = M_FINISH;
					end else if (s.rechk) begin
						// still toggling after the limit flag: give up
						next_s.resp.timing_fail = 1'b1;
						next_s.op = OP_RESET;
						next_s.step = 3'h0;
						next_s.st = M_WRITE;
					end else begin
						next_s.rechk = cyc_rdata[TIMING_LIMIT_FLAG];
						next_s.st = M_POLL_A;
					end
				end
			end
			M_PRE_CHK: begin
				if (rd_done) begin
					next_s.resp.data = cyc_rdata;
					if (cyc_rdata[ERASE_TIMER_FLAG]) begin
						// window closed: another sector would be ignored
						next_s.resp.rejected = 1'b1;
						next_s.st = M_FINISH;
					end else begin
						next_s.st = M_WRITE;
					end
				end
			end
			M_POST_CHK: begin
				if (rd_done) begin
					next_s.resp.data = cyc_rdata;
					// flag already high: the added sector may have been lost
					next_s.resp.late_timer = cyc_rdata[ERASE_TIMER_FLAG];
					next_s.st = M_FINISH;
				end
			end
			M_READ: begin
				// a separate read, so data after completion is whole
				if (rd_done) begin
					next_s.resp.data = cyc_rdata;
					next_s.st = M_FINISH;
				end
			end
			M_FINISH: begin
				next_s.resp.ok = !(s.resp.timing_fail || s.resp.rejected);
				next_s.resp.ready = ready_busy_n;
				next_s.resp_valid = 1'b1;
				next_s.st = M_IDLE;
			end
			default: begin
				next_s.st = M_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s <= '{st: M_IDLE, op: OP_READ, addr: 22'h000000, data: 8'h00,
				poll: 1'b0, step: 3'h0, issued: 1'b0, first_toggle: 1'b0,
				rechk: 1'b0, resp_valid: 1'b0, resp: '0};
		end else begin
			s <= next_s;
		end
	end

	assign req_ready = (s.st == M_IDLE);
	assign resp_valid = s.resp_valid;
	assign resp = s.resp;

endmodule
`default_nettype wire

// *** tb/fwsr_host_assertions.sv ***
// port checker for the flash write-status host controller
`timescale 1ns/1ps
`default_nettype none
module fwsr_host_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire fwsr_pkg::fwsr_req_type req,
	input wire logic resp_valid,
	input wire fwsr_pkg::fwsr_resp_type resp,
	input wire fwsr_pkg::fwsr_pins_type flash_pins
);
	import fwsr_pkg::*;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	wire logic we_n = flash_pins.we_n;
	wire logic oe_n = flash_pins.oe_n;
	wire logic oe = flash_pins.dq_oe;
	wire logic take = req_valid && req_ready;
	property p_excl; !(!we_n && !oe_n); endproperty
	a_excl: assert property (p_excl) else $error("strobe overlap");
	property p_we_ce; !we_n |-> !flash_pins.ce_n && oe; endproperty
	a_we_ce: assert property (p_we_ce) else $error("bad write");
	property p_we_len; $fell(we_n) |-> !we_n [*3] ##1 we_n; endproperty
	a_we_len: assert property (p_we_len) else $error("write len");
	property p_oe_len; $fell(oe_n) |-> !oe_n [*3] ##1 oe_n; endproperty
	a_oe_len: assert property (p_oe_len) else $error("read len");
	property p_recov; $rose(we_n) |-> oe ##1 oe; endproperty
	a_recov: assert property (p_recov) else $error("data hold");
	property p_pulse; resp_valid |=> !resp_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("resp pulse");
	property p_take; take |=> !req_ready; endproperty
	a_take: assert property (p_take) else $error("still ready");
	property p_free; resp_valid |-> req_ready; endproperty
	a_free: assert property (p_free) else $error("not ready");
	property p_fail; resp_valid && resp.timing_fail |-> !resp.ok; endproperty
	a_fail: assert property (p_fail) else $error("fail with ok");
	// take, start, setup, 3 strobe, 2 recover, done, finish, then the pulse
	property p_rd; take && req.op == OP_READ |-> ##10 resp_valid; endproperty
	a_rd: assert property (p_rd) else $error("read latency");
	c_fail: cover property (resp_valid && resp.timing_fail);
	c_rej: cover property (resp_valid && resp.rejected);
	c_ok: cover property (resp_valid && resp.ok);
endmodule
bind fwsr_host fwsr_host_checker u_chk (.mclk, .rstn, .req_valid,
	.req_ready, .req, .resp_valid, .resp, .flash_pins);
`default_nettype wire

// *** tb/fwsr_flash_model.sv ***
// behavioural flash device answering bus cycles with write status
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model #(
	parameter int BUSY = 60,
	parameter int TMR = 100
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire fwsr_pkg::fwsr_pins_type pins,
	input wire logic fail_mode,
	output logic [7:0] dq_in,
	output logic ready_busy_n
);
	import fwsr_pkg::*;
	// ----------------------------------------------------------------
	// one-byte array; protection, suspend and sector address not modelled
	// ----------------------------------------------------------------
	logic pw, po, pgm, ers, t6, t2, flt, stk;
	logic [7:0] arr, pd, d;
	int bsy, tmr;
	wire logic act = bsy != 0 || tmr != 0;
	// a stuck program never ends; only the limit flag tells the host
	wire logic hang = fail_mode || stk;
	assign d = pins.dq_out;
	// pulled up when released
	assign ready_busy_n = !act;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{pw, po, pgm, ers, t6, t2, flt, stk} <= 8'hC0;
			{arr, pd, dq_in} <= 24'hFFFFFF;
			{bsy, tmr} <= '0;
		end else begin
			pw <= pins.we_n;
			po <= pins.oe_n;
			if (act && hang) flt <= 1'h1;
			if (tmr != 0) tmr <= tmr - 1;
			else if (bsy > 1 && !hang) bsy <= bsy - 1;
			else if (bsy == 1) begin
				bsy <= 0;
				arr <= ers ? 8'hFF : pd;
			end
			if (pins.we_n && !pw) begin
				if (d == CMD_RESET) begin
					{bsy, tmr} <= '0;
					{flt, ers, stk} <= 3'h0;
				end else if (pgm) begin
					pgm <= 1'h0;
					pd <= d;
					stk <= |(d & ~arr);
					ers <= 1'h0;
					bsy <= BUSY;
				end else if (d == CMD_PROGRAM) pgm <= 1'h1;
				else if (d == CMD_CHIP_ERASE ||
					d == CMD_SECTOR_ERASE && (tmr != 0 || !act)) begin
					ers <= 1'h1;
					bsy <= BUSY;
					tmr <= (d == CMD_CHIP_ERASE) ? 0 : TMR;
				end
			end
			if (!pins.oe_n && po) begin
				t6 <= ~t6;
				t2 <= ~t2;
				dq_in <= act ? {ers ? 1'h0 : ~pd[7], t6, flt, 1'h0,
					tmr == 0, ers & t2, 2'h0} : arr;
			end else if (pins.oe_n) dq_in <= ~dq_in;
		end
	end
endmodule
`default_nettype wire

// *** tb/fwsr_host_tb_top.sv ***
// bench for the flash write-status host controller
`timescale 1ns/1ps
`default_nettype none
module fwsr_host_tb_top;
	import fwsr_pkg::*;
	typedef struct {
		fwsr_op_type op;
		logic [21:0] addr;
		logic [7:0] data;
		int gap;
		logic [3:0] flg;
		logic [7:0] dat;
	} fwsr_row_type;
	// flags: timing_fail, rejected, late_timer, ready
	fwsr_row_type rows [9] = '{
		'{OP_PROGRAM, 22'h010000, 8'h5A, 0, 4'h1, 8'h00},
		'{OP_READ, 22'h010000, 8'h00, 0, 4'h1, 8'h5A},
		'{OP_SECT_ERASE, 22'h020000, 8'h30, 0, 4'h0, 8'h00},
		'{OP_SECT_ADD, 22'h030000, 8'h30, 0, 4'h0, 8'h00},
		'{OP_SECT_ADD, 22'h030000, 8'h30, 130, 4'h4, 8'h00},
		'{OP_POLL, 22'h030000, 8'h00, 0, 4'h1, 8'h00},
		'{OP_READ, 22'h030000, 8'h00, 0, 4'h1, 8'hFF},
		'{OP_CHIP_ERASE, 22'h000000, 8'h10, 0, 4'h1, 8'h00},
		'{OP_RESET, 22'h000000, 8'hF0, 0, 4'h1, 8'h00}
	};
	logic mclk, rstn, req_valid, req_ready, resp_valid, fail_mode, rb_n;
	fwsr_req_type req;
	fwsr_resp_type resp;
	fwsr_pins_type flash_pins;
	logic [7:0] dev_dq, dq_bus;
	int bad_count = 0;
	int checks_done = 0;
	// host drive wins the shared data bus while enabled
	assign dq_bus = flash_pins.dq_oe ? flash_pins.dq_out : dev_dq;
	fwsr_host dut_u (.mclk, .rstn, .req_valid, .req_ready, .req,
		.resp_valid, .resp, .flash_pins, .dq_in(dq_bus),
		.ready_busy_n(rb_n));
	fwsr_flash_model #(.BUSY(60), .TMR(100)) flash_u (.mclk, .rstn,
		.pins(flash_pins), .fail_mode, .dq_in(dev_dq),
		.ready_busy_n(rb_n));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (bad_count == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic start(fwsr_op_type op, logic [21:0] a, logic [7:0] d);
		@(posedge mclk);
		#1;
		req = '{op: op, addr: a, data: d, poll: 1'h0};
		req_valid = 1'h1;
		while (req_ready !== 1'h1) begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
		req_valid = 1'h0;
	endtask
	// bounded wait: polling may never end on a broken device
	task automatic run(fwsr_op_type op, logic [21:0] a, logic [7:0] d);
		int n;
		n = 0;
		start(op, a, d);
		while (resp_valid !== 1'h1 && n < 4000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("resp_wait", n < 4000, 1'h1);
	endtask
	task automatic rst_chk();
		chk("req_ready", req_ready, 1'h1);
		chk("resp_valid", resp_valid, 1'h0);
		chk("resp", resp, '0);
		chk("pins", flash_pins, PINS_IDLE);
	endtask
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#500000;
		bad_count++;
		give_verdict();
	end
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{rstn, req_valid, fail_mode} = 3'h0;
		req = '0;
		repeat (4) @(posedge mclk);
		#1;
		rst_chk();
		rstn = 1'h1;
		foreach (rows[i]) begin
			repeat (rows[i].gap) @(posedge mclk);
			run(rows[i].op, rows[i].addr, rows[i].data);
			chk("flags", {resp.timing_fail, resp.rejected,
				resp.late_timer, resp.ready}, rows[i].flg);
			if (rows[i].op == OP_READ)
				chk("data", resp.data, rows[i].dat);
		end
		fail_mode = 1'h1;
		run(OP_PROGRAM, 22'h010000, 8'h33);
		chk("fail", {resp.ok, resp.timing_fail}, 2'h1);
		fail_mode = 1'h0;
		run(OP_READ, 22'h010000, 8'h00);
		chk("after_fail", {resp.ready, resp.data}, 9'h1FF);
		run(OP_PROGRAM, 22'h010000, 8'h00);
		chk("zero_prog", {resp.ok, resp.timing_fail}, 2'h2);
		run(OP_PROGRAM, 22'h010000, 8'h33);
		chk("one_over_zero", {resp.ok, resp.timing_fail}, 2'h1);
		fail_mode = 1'h1;
		start(OP_PROGRAM, 22'h010000, 8'h77);
		repeat (40) @(posedge mclk);
		#1;
		rstn = 1'h0;
		#1;
		rst_chk();
		repeat (4) @(posedge mclk);
		#1;
		rstn = 1'h1;
		fail_mode = 1'h0;
		run(OP_READ, 22'h010000, 8'h00);
		chk("reread", resp.data, 8'hFF);
		give_verdict();
	end
endmodule
`default_nettype wire
